// ==== verilog/gpio_altfunc_mux.sv ====
// GPIO bank: output/enable registers, per-pin function selection, boot
// straps, management-slave takeover and the input-change interrupt.
// Assumes one 10 MHz clock, pads that resolve drive from pad_oe_out, and
// overlaid peripherals running on the same clock.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "gpio_mux_map.svh"

module gpio_altfunc_mux (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Register port.
  input wire logic [`ADDR_W-1:0] reg_addr_in,
  input wire gpio_mux_pkg::pin_vec_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output gpio_mux_pkg::pin_vec_t reg_rdata_out,
  // Pads.
  input wire gpio_mux_pkg::pin_vec_t pad_in,
  output gpio_mux_pkg::pin_vec_t pad_out,
  output gpio_mux_pkg::pin_vec_t pad_oe_out,
  // Overlaid peripheral groups.
  input wire gpio_mux_pkg::pin_drive_t func1_drive_in,
  input wire gpio_mux_pkg::pin_drive_t func2_drive_in,
  input wire gpio_mux_pkg::pin_drive_t func3_drive_in,
  output gpio_mux_pkg::pin_vec_t pin_level_out,
  output gpio_mux_pkg::func_vec_t pin_function_out,
  // Management slave.
  input wire logic mgmt_data_drive_in,
  input wire logic mgmt_data_oe_in,
  output logic slave_mgmt_clock_pin_out,
  output logic slave_mgmt_data_pin_out,
  output logic mgmt_slave_active_out,
  // Straps and interrupt.
  output logic [3:0] boot_config_straps_out,
  output logic pin_change_irq_out
);

  // ===========================================================
  // Declarations.
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic soft_rst_reg;
  gpio_mux_pkg::pin_vec_t sync1_reg;
  gpio_mux_pkg::pin_vec_t sync2_reg;
  gpio_mux_pkg::pin_vec_t prev_reg;
  logic primed_reg;
  gpio_mux_pkg::pin_vec_t out_value_reg;
  gpio_mux_pkg::pin_vec_t oe_reg;
  gpio_mux_pkg::pin_vec_t alt0_reg;
  gpio_mux_pkg::pin_vec_t alt1_reg;
  gpio_mux_pkg::pin_vec_t flags_reg;
  gpio_mux_pkg::pin_vec_t mask_reg;
  logic [3:0] strap_reg;
  gpio_mux_pkg::pin_vec_t rdata_reg;
  gpio_mux_pkg::pin_vec_t pad_out_reg;
  gpio_mux_pkg::pin_vec_t pad_oe_reg;
  logic irq_reg;
  gpio_mux_pkg::pin_vec_t pad_out_next;
  gpio_mux_pkg::pin_vec_t pad_oe_next;
  gpio_mux_pkg::pin_vec_t change;
  gpio_mux_pkg::pin_vec_t ident;
  gpio_mux_pkg::func_vec_t codes;
  logic mgmt_active;
  logic wr_out;
  logic wr_set;
  logic wr_clr;
  logic wr_oe;
  logic wr_alt0;
  logic wr_alt1;
  logic wr_flags;
  logic wr_mask;
  logic wr_ctrl;

  // ===========================================================
  // Helpers.

  // Upper bit is the second alternate register, lower bit the first.
  function automatic gpio_mux_pkg::func_code_t func_code(input logic hi, input logic lo,
                                                         input logic has3);
    gpio_mux_pkg::func_code_t c;
    c = {hi, lo};
    // A pin with no third function falls back to plain GPIO on code 3.
    if (c == 2'h3 && !has3) begin
      c = 2'h0;
    end
    return c;
  endfunction

  // True when the bus index names the given word; the strobe is gated at the caller.
  // Both sides are arguments so a continuous assignment re-evaluates on every address change.
  function automatic logic hit(input logic [`ADDR_W-1:0] addr, input logic [`ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // ===========================================================
  // Reset release.

  // Asynchronous assertion, release through two flops to avoid metastable removal.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  // ===========================================================
  // Write decode.
  assign wr_out = reg_wr_in && hit(reg_addr_in, `OFS_OUT);
  assign wr_set = reg_wr_in && hit(reg_addr_in, `OFS_OUT_SET);
  assign wr_clr = reg_wr_in && hit(reg_addr_in, `OFS_OUT_CLR);
  assign wr_oe = reg_wr_in && hit(reg_addr_in, `OFS_OE);
  assign wr_alt0 = reg_wr_in && hit(reg_addr_in, `OFS_ALT0);
  assign wr_alt1 = reg_wr_in && hit(reg_addr_in, `OFS_ALT1);
  assign wr_flags = reg_wr_in && hit(reg_addr_in, `OFS_FLAGS);
  assign wr_mask = reg_wr_in && hit(reg_addr_in, `OFS_MASK);
  assign wr_ctrl = reg_wr_in && hit(reg_addr_in, `OFS_CTRL);

  // Software reset is a one-cycle pulse; it clears the bank but not the mapping.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_ctrl && reg_wdata_in[`CTRL_SOFT_RST_BIT];
    end
  end

  // ===========================================================
  // Pad input synchronisers.

  // Plain data flops; the first stage feeds only the second.
  always_ff @(posedge core_clk_in) begin
    sync1_reg <= pad_in;
    sync2_reg <= sync1_reg;
  end

  // ===========================================================
  // Boot straps.

  // Captured on every edge while reset is held, frozen once it is released.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n) begin
      strap_reg <= sync2_reg[`STRAP_MSB:`STRAP_LSB];
    end
  end

  assign mgmt_active = (strap_reg == `STRAP_MGMT_SLAVE);

  // ===========================================================
  // Output value and output enable.

  // Set and clear aliases touch only bits written as one, so threads need no lock.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_value_reg <= `RST_VEC;
    end else if (soft_rst_reg) begin
      out_value_reg <= `RST_VEC;
    end else if (wr_out) begin
      out_value_reg <= reg_wdata_in;
    end else if (wr_set) begin
      out_value_reg <= out_value_reg | reg_wdata_in;
    end else if (wr_clr) begin
      out_value_reg <= out_value_reg & ~reg_wdata_in;
    end
  end

  // Every pin comes up as an input.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg <= `RST_VEC;
    end else if (soft_rst_reg) begin
      oe_reg <= `RST_VEC;
    end else if (wr_oe) begin
      oe_reg <= reg_wdata_in;
    end
  end

  // ===========================================================
  // Function selection.

  // Only the external reset reaches these, so a software reset keeps the mapping.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      alt0_reg <= `RST_VEC;
      alt1_reg <= `RST_VEC;
    end else begin
      if (wr_alt0) begin
        alt0_reg <= reg_wdata_in;
      end
      if (wr_alt1) begin
        alt1_reg <= reg_wdata_in;
      end
    end
  end

  // Per-pin code and pad drive selection.
  always_comb begin
    pad_out_next = `RST_VEC;
    pad_oe_next = `RST_VEC;
    for (int i = 0; i < `PIN_W; i++) begin
      codes[i] = func_code(alt1_reg[i], alt0_reg[i], 1'(`FUNC3_PRESENT >> i));
      unique case (codes[i])
        2'h0: begin
          pad_out_next[i] = out_value_reg[i];
          pad_oe_next[i] = oe_reg[i];
        end
        2'h1: begin
          pad_out_next[i] = func1_drive_in.dout[i];
          pad_oe_next[i] = func1_drive_in.oe[i];
        end
        2'h2: begin
          pad_out_next[i] = func2_drive_in.dout[i];
          pad_oe_next[i] = func2_drive_in.oe[i];
        end
        2'h3: begin
          pad_out_next[i] = func3_drive_in.dout[i];
          pad_oe_next[i] = func3_drive_in.oe[i];
        end
      endcase
    end
    // The strap overrides the selection: clock is an input, data is bidirectional.
    if (mgmt_active) begin
      pad_out_next[`MGMT_CLK_PIN] = 1'b0;
      pad_oe_next[`MGMT_CLK_PIN] = 1'b0;
      pad_out_next[`MGMT_DATA_PIN] = mgmt_data_drive_in;
      pad_oe_next[`MGMT_DATA_PIN] = mgmt_data_oe_in;
    end
  end

  // Pads are registered; during reset nothing drives so straps read clean.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_reg <= `RST_VEC;
      pad_oe_reg <= `RST_VEC;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= pad_oe_next;
    end
  end

  // ===========================================================
  // Input change detection.

  // The first cycle after reset only primes the history, so no false flags.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= `RST_VEC;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= sync2_reg;
      primed_reg <= 1'b1;
    end
  end

  assign change = primed_reg ? (sync2_reg ^ prev_reg) : `RST_VEC;

  // Write one to clear; a change in the same cycle wins over the clear.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `RST_VEC;
    end else if (soft_rst_reg) begin
      flags_reg <= change;
    end else begin
      flags_reg <= (flags_reg & ~(wr_flags ? reg_wdata_in : `RST_VEC)) | change;
    end
  end

  // Interrupt enable mask.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `RST_VEC;
    end else if (soft_rst_reg) begin
      mask_reg <= `RST_VEC;
    end else if (wr_mask) begin
      mask_reg <= reg_wdata_in;
    end
  end

  assign ident = flags_reg & mask_reg;

  // Registered request toward the interrupt controller.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |ident;
    end
  end

  // ===========================================================
  // Register reads.

  // Data stands one cycle after the read strobe and reads zero otherwise.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `RST_VEC;
    end else if (!reg_rd_in) begin
      rdata_reg <= `RST_VEC;
    end else begin
      case (reg_addr_in)
        `OFS_OUT: rdata_reg <= out_value_reg;
        `OFS_IN: rdata_reg <= sync2_reg;
        `OFS_OE: rdata_reg <= oe_reg;
        `OFS_ALT0: rdata_reg <= alt0_reg;
        `OFS_ALT1: rdata_reg <= alt1_reg;
        `OFS_FLAGS: rdata_reg <= flags_reg;
        `OFS_MASK: rdata_reg <= mask_reg;
        `OFS_IDENT: rdata_reg <= ident;
        `OFS_STRAPS: rdata_reg <= {33'h000000000, strap_reg};
        default: rdata_reg <= `RST_VEC;
      endcase
    end
  end

  // ===========================================================
  // Outputs.
  assign reg_rdata_out = rdata_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe_out = pad_oe_reg;
  assign pin_level_out = sync2_reg;
  assign pin_function_out = codes;
  assign slave_mgmt_clock_pin_out = sync2_reg[`MGMT_CLK_PIN];
  assign slave_mgmt_data_pin_out = sync2_reg[`MGMT_DATA_PIN];
  assign mgmt_slave_active_out = mgmt_active;
  assign boot_config_straps_out = strap_reg;
  assign pin_change_irq_out = irq_reg;

endmodule

// ==== verilog/gpio_mux_map.svh ====
// Constants for the GPIO function mux: offsets, field positions, resets, masks.
// Assumes a single 10 MHz core clock and a plain register port with word indices.
//
// Behaviour
// - Two alternate bits form each pin's code
// - Replicated alternate registers select per-pin functions
// - Management-slave strap takes over pins 22, 23
// - Straps on pins 33-36 latched during reset
// - Strap pins become ordinary pins after reset
// - Any input change sets that pin's flag
// - Interrupt forwarded only for enabled flagged pins
// - Identify reads flags AND enable mask
// - Pins default input; outputs drive output value
// - Input register shows current pin levels
// - Alternate registers ignore software reset
// - Set/clear aliases change only written-one bits
`ifndef GPIO_MUX_MAP_SVH
`define GPIO_MUX_MAP_SVH

// ===========================================================
// Bank size and register port widths.
`define PIN_W 37
`define ADDR_W 4

// ===========================================================
// Register word indices.
`define OFS_OUT 4'h0
`define OFS_OUT_SET 4'h1
`define OFS_OUT_CLR 4'h2
`define OFS_IN 4'h3
`define OFS_OE 4'h4
`define OFS_ALT0 4'h5
`define OFS_ALT1 4'h6
`define OFS_FLAGS 4'h7
`define OFS_MASK 4'h8
`define OFS_IDENT 4'h9
`define OFS_STRAPS 4'ha
`define OFS_CTRL 4'hb

// ===========================================================
// Field positions and reset values.
`define CTRL_SOFT_RST_BIT 0
`define STRAP_LSB 33
`define STRAP_MSB 36
`define MGMT_CLK_PIN 22
`define MGMT_DATA_PIN 23
`define STRAP_MGMT_SLAVE 4'h5
`define RST_VEC 37'h0000000000
`define FUNC3_PRESENT 37'h001edffff0

`endif

// ==== verilog/gpio_mux_pkg.sv ====
// Types shared by the GPIO function mux and its neighbours.
// Assumes the constants header is on the include path.
`include "gpio_mux_map.svh"

package gpio_mux_pkg;

  // ===========================================================
  // One bank-wide vector and a per-pin function code.
  typedef logic [`PIN_W-1:0] pin_vec_t;
  typedef logic [1:0] func_code_t;
  typedef func_code_t [`PIN_W-1:0] func_vec_t;

  // Drive request from one overlaid peripheral group.
  typedef struct packed {
    pin_vec_t dout;
    pin_vec_t oe;
  } pin_drive_t;

endpackage

// ==== tb/gpio_mux_props.sv ====
// Checker bound to the GPIO function mux top; it sees only the top's ports.
// Assumes the map header and the package compile before this file.
`timescale 1ns/100ps
`include "gpio_mux_map.svh"

module gpio_mux_props (
  // Clock, reset and register port.
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [`ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire gpio_mux_pkg::pin_vec_t reg_rdata_out,
  // Pads, management slave, straps and interrupt.
  input wire gpio_mux_pkg::pin_vec_t pad_in,
  input wire gpio_mux_pkg::pin_vec_t pad_out,
  input wire gpio_mux_pkg::pin_vec_t pad_oe_out,
  input wire gpio_mux_pkg::pin_vec_t pin_level_out,
  input wire logic mgmt_data_drive_in,
  input wire logic mgmt_data_oe_in,
  input wire logic slave_mgmt_clock_pin_out,
  input wire logic mgmt_slave_active_out,
  input wire logic [3:0] boot_config_straps_out,
  input wire logic pin_change_irq_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // ==========
  // Edges since release; the syncs and the straps have settled past four.
  logic [2:0] up_reg;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end

  // ==========
  // Port relations.
  rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 37'h0)
    else $error("read data outside its cycle");
  level_sync_a: assert property (up_reg > 3'h4 |-> pin_level_out == $past(pad_in, 2))
    else $error("pin level lag wrong");
  mgmt_clk_a: assert property (
    up_reg > 3'h4 |-> slave_mgmt_clock_pin_out == $past(pad_in[`MGMT_CLK_PIN], 2))
    else $error("slave clock not following pin");
  mgmt_flag_a: assert property (
    up_reg > 3'h4 |-> mgmt_slave_active_out == (boot_config_straps_out == `STRAP_MGMT_SLAVE))
    else $error("slave mode flag wrong");
  mgmt_take_a: assert property (
    up_reg > 3'h4 && mgmt_slave_active_out |-> !pad_oe_out[`MGMT_CLK_PIN]
      && pad_oe_out[`MGMT_DATA_PIN] == $past(mgmt_data_oe_in)
      && pad_out[`MGMT_DATA_PIN] == $past(mgmt_data_drive_in))
    else $error("slave pins not taken over");
  strap_hold_a: assert property (up_reg > 3'h4 |-> $stable(boot_config_straps_out))
    else $error("straps moved after reset");
  quiet_start_a: assert property (
    up_reg < 3'h3 |-> pad_oe_out == 37'h0 && !pin_change_irq_out)
    else $error("pins driven right after reset");
  ident_irq_a: assert property (
    $past(reg_rd_in && reg_addr_in == `OFS_IDENT) |-> (|reg_rdata_out) == pin_change_irq_out)
    else $error("identify and interrupt disagree");
endmodule

bind gpio_altfunc_mux gpio_mux_props chk_u (.*);

// ==== tb/pin_board_model.sv ====
// Board model: each pad shows the bank's drive when enabled, else the board level.
// Assumes the bench sets the board level of every pin.
`timescale 1ns/100ps

module pin_board_model (
  // Bank side.
  input wire gpio_mux_pkg::pin_vec_t drive_in,
  input wire gpio_mux_pkg::pin_vec_t oe_in,
  // Board side.
  input wire gpio_mux_pkg::pin_vec_t board_lvl_in,
  output gpio_mux_pkg::pin_vec_t pad_lvl_out
);
  // No contention is modelled: a driven pad simply wins over the board.
  assign pad_lvl_out = (drive_in & oe_in) | (board_lvl_in & ~oe_in);
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the GPIO function mux with a board model on its pads.
// Assumes header, package, design, checker and board model compile first.
`timescale 1ns/100ps
`include "gpio_mux_map.svh"

module tb;
  // ==========
  // Design signals carry the port names so the instance connects by name.
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [`ADDR_W-1:0] reg_addr_in = 4'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic mgmt_data_drive_in = 1'b0;
  logic mgmt_data_oe_in = 1'b0;
  gpio_mux_pkg::pin_vec_t reg_wdata_in = 37'h0;
  gpio_mux_pkg::pin_vec_t reg_rdata_out, pad_in, pad_out, pad_oe_out, pin_level_out;
  gpio_mux_pkg::pin_drive_t func1_drive_in = 74'h0;
  gpio_mux_pkg::pin_drive_t func2_drive_in = 74'h0;
  gpio_mux_pkg::pin_drive_t func3_drive_in = 74'h0;
  gpio_mux_pkg::func_vec_t pin_function_out;
  logic slave_mgmt_clock_pin_out, slave_mgmt_data_pin_out, mgmt_slave_active_out;
  logic pin_change_irq_out;
  logic [3:0] boot_config_straps_out;
  gpio_mux_pkg::pin_vec_t board = 37'h0;
  gpio_mux_pkg::pin_vec_t fp = `FUNC3_PRESENT;
  gpio_mux_pkg::pin_vec_t q[$];
  logic rd_seen = 1'b0;
  logic [63:0] rs = 64'h3d15;
  int miscompares = 0;
  int comparisons = 0;

  gpio_altfunc_mux dut_u (.*);
  pin_board_model board_u (.drive_in(pad_out), .oe_in(pad_oe_out), .board_lvl_in(board),
    .pad_lvl_out(pad_in));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end

  // ==========
  // Helpers.
  function automatic logic [63:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 7);
    rs = rs ^ (rs << 17);
    return rs;
  endfunction

  task automatic chk(input string n, input gpio_mux_pkg::pin_vec_t e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // One access per call; strobes stay up so calls run back to back.
  task automatic acc(input logic w, input logic [3:0] a, input gpio_mux_pkg::pin_vec_t d);
    @(posedge core_clk_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (!w) q.push_back(d);
  endtask

  task automatic idle(input int n);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (n) @(posedge core_clk_in);
  endtask

  // Held two edges; the internal reset lags by two more, so the straps see synced pins.
  task automatic hw_reset(input logic [3:0] s);
    reset_n_in <= 1'b0;
    board[`STRAP_MSB:`STRAP_LSB] <= s;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
  endtask

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read answers stand one cycle after the strobe; compare them mid-cycle.
  always @(posedge core_clk_in) rd_seen <= reg_rd_in;
  always @(negedge core_clk_in) begin
    if (rd_seen) chk("rdata", q.pop_front(), reg_rdata_out);
  end

  initial begin
    repeat (3000) @(posedge core_clk_in);
    miscompares++;
    close_out();
  end

  // ==========
  // Scenarios.
  initial begin
    gpio_mux_pkg::pin_vec_t p, v, s, c, e, ch, m, a0, a1, gd, go;
    gpio_mux_pkg::func_vec_t code;
    hw_reset(4'ha);
    chk("straps", 37'h0a, 37'(boot_config_straps_out));
    chk("pad_oe", 37'h0, pad_oe_out);
    acc(0, `OFS_OE, 37'h0);
    acc(0, `OFS_ALT1, 37'h0);
    p = board;
    v = 37'(rnd());
    s = 37'(rnd());
    c = 37'(rnd());
    e = (v | s) & ~c;
    acc(1, `OFS_OUT, v);
    acc(1, `OFS_OE, ~37'h0);
    acc(1, `OFS_OUT_SET, s);
    acc(1, `OFS_OUT_CLR, c);
    acc(0, `OFS_OUT, e);
    idle(6);
    chk("pad_out", e, pad_out);
    acc(0, `OFS_IN, e);
    ch = (p ^ v) | (v ^ (v | s)) | ((v | s) ^ e);
    m = 37'(rnd());
    acc(0, `OFS_FLAGS, ch);
    acc(1, `OFS_MASK, m);
    acc(0, `OFS_IDENT, ch & m);
    idle(2);
    chk("irq", 37'(|(ch & m)), 37'(pin_change_irq_out));
    acc(1, `OFS_MASK, 37'h0);
    acc(1, `OFS_FLAGS, ch);
    acc(0, `OFS_FLAGS, 37'h0);
    idle(2);
    chk("irq", 37'h0, 37'(pin_change_irq_out));
    // Random codes per pin cover all four selections on every pass.
    for (int i = 0; i < 4; i++) begin
      a0 = 37'(rnd());
      a1 = 37'(rnd());
      acc(1, `OFS_ALT0, a0);
      acc(1, `OFS_ALT1, a1);
      func1_drive_in <= 74'({rnd(), rnd()});
      func2_drive_in <= 74'({rnd(), rnd()});
      func3_drive_in <= 74'({rnd(), rnd()});
      idle(3);
      for (int n = 0; n < `PIN_W; n++) begin
        code[n] = {a1[n], a0[n]};
        if (code[n] == 2'h3 && !fp[n]) code[n] = 2'h0;
        chk("function", 37'(code[n]), 37'(pin_function_out[n]));
        case (code[n])
          2'h1: {gd[n], go[n]} = {func1_drive_in.dout[n], func1_drive_in.oe[n]};
          2'h2: {gd[n], go[n]} = {func2_drive_in.dout[n], func2_drive_in.oe[n]};
          2'h3: {gd[n], go[n]} = {func3_drive_in.dout[n], func3_drive_in.oe[n]};
          default: {gd[n], go[n]} = {e[n], 1'b1};
        endcase
      end
      chk("pad_out", gd, pad_out);
      chk("pad_oe", go, pad_oe_out);
    end
    // Soft reset spares the function selection; unmapped places read zero.
    acc(1, `OFS_CTRL, 37'h1);
    acc(0, `OFS_ALT0, a0);
    acc(0, `OFS_ALT1, a1);
    acc(0, `OFS_OE, 37'h0);
    acc(1, 4'hc, v);
    acc(0, 4'hc, 37'h0);
    idle(2);
    chk("straps", 37'h0a, 37'(boot_config_straps_out));
    // Second reset with the slave strap code takes over the two slave pins.
    hw_reset(`STRAP_MGMT_SLAVE);
    chk("active", 37'h1, 37'(mgmt_slave_active_out));
    acc(0, `OFS_ALT0, 37'h0);
    acc(1, `OFS_OE, ~37'h0);
    acc(1, `OFS_ALT0, ~37'h0);
    mgmt_data_oe_in <= 1'b1;
    mgmt_data_drive_in <= ^rnd();
    board[`MGMT_CLK_PIN] <= 1'b1;
    idle(4);
    chk("slave_oe", 37'h2, 37'({pad_oe_out[23], pad_oe_out[22]}));
    chk("slave_data", 37'(mgmt_data_drive_in), 37'(pad_out[23]));
    chk("slave_clock", 37'h1, 37'(slave_mgmt_clock_pin_out));
    chk("slave_din", 37'(mgmt_data_drive_in), 37'(slave_mgmt_data_pin_out));
    idle(2);
    close_out();
  end
endmodule
